// file: hdl/ghr_params.svh
// Constants of the graphics host register decode: offsets, fields, resets and timing.
// Behaviour
// R1: Write-only byte at 00H holds horizontal coordinate bits 0 to 7.
// R2: Write-only byte at 01H holds horizontal coordinate bits 8 to 11.
// R3: Write-only byte at 02H holds vertical coordinate bits 0 to 7.
// R4: Write-only byte at 03H holds vertical coordinate bits 8 to 11.
// R5: Offsets 04H and 05H are read/write pixel data ports, strap-selected lanes.
// R6: Reading 06H gives status; writing 06H loads the first control register.
// R7: First control holds video, double resolution, DMA, frame grab and preset.
// R8: Host initialises the first control register by writing it twice.
// R9: Writing 07H loads pan and zoom control.
// R10: Reading 08H gives the light pen position within the cell.
// R11: Writes to 08H and 09H load the per-plane video output mask.
// R12: Writes to 0AH and 0BH load the plane write mask, also used in preset.
// R13: Reading 0CH gives vertical blanking and pen-loaded flags.
// R14: Writing 0CH selects a timing register; 0EH reads or writes it; 14 exist.
// R15: Writing 0FH steps coordinates up or down and may write the pixel.
// R16: Host writes a timing index first, then its value.
// R17: Data 00H then control A0H presets all memory with the data value.
// R18: The timing controller works in 8 x 8 pixel cells on a cell clock.
// R19: Host loads the plane write mask with ones before memory access.
// R20: A one in coordinate high bits 1 to 3 blocks memory access; the code does not block it in DMA mode.
// R21: Status bit 7 is one while preset or frame grab is in progress.
// R22: In DMA mode coordinates increment before each transferred byte.
// R23: Control bit 2 floats the TTL video; bit 3 doubles horizontal resolution.
// R24: Low four address bits select one of sixteen locations above the base.
`ifndef GHR_PARAMS_SVH
`define GHR_PARAMS_SVH

`define GHR_OFS_X_LOW        4'h0
`define GHR_OFS_X_HIGH       4'h1
`define GHR_OFS_Y_LOW        4'h2
`define GHR_OFS_Y_HIGH       4'h3
`define GHR_OFS_DATA_LOW     4'h4
`define GHR_OFS_DATA_HIGH    4'h5
`define GHR_OFS_STATUS_CTRL1 4'h6
`define GHR_OFS_PAN_ZOOM     4'h7
`define GHR_OFS_PEN_OMASK_LO 4'h8
`define GHR_OFS_OMASK_HI     4'h9
`define GHR_OFS_WMASK_LO     4'ha
`define GHR_OFS_WMASK_HI     4'hb
`define GHR_OFS_TSTAT_INDEX  4'hc
`define GHR_OFS_TPORT        4'he
`define GHR_OFS_LINE_STEP    4'hf

`define GHR_CTRL1_FLOAT_BIT  2
`define GHR_CTRL1_DBLRES_BIT 3
`define GHR_CTRL1_DMA_BIT    4
`define GHR_CTRL1_FREEZE_BIT 5
`define GHR_CTRL1_PRESET_BIT 7
`define GHR_STAT_BUSY_BIT    7
`define GHR_STAT_PRESET_N    0
`define GHR_STEP_X_INC       0
`define GHR_STEP_X_DEC       1
`define GHR_STEP_Y_INC       2
`define GHR_STEP_Y_DEC       3
`define GHR_STEP_WRITE       4
`define GHR_TSTAT_PEN_BIT    6
`define GHR_TSTAT_VBL_BIT    5

`define GHR_RST_CTRL1        8'h20
`define GHR_RST_PAN_ZOOM     8'h20
`define GHR_RST_MASK         16'hffff
`define GHR_TIMING_REGS      14
`define GHR_CELL_SIZE        8

`define GHR_CLK_MHZ          10
`define GHR_ACK_SLOW_NS      500
`define GHR_ACK_FAST_NS      50
`define GHR_ACK_SLOW_CYC     ((`GHR_ACK_SLOW_NS * `GHR_CLK_MHZ) / 1000)
`define GHR_ACK_FAST_CYC     (((`GHR_ACK_FAST_NS * `GHR_CLK_MHZ) + 999) / 1000)
`define GHR_FRAME_US         20000
`define GHR_FRAME_CYC        (`GHR_FRAME_US * `GHR_CLK_MHZ)

`endif

// file: hdl/ghr_pkg.sv
// Types shared by the graphics host register decode.
package ghr_pkg;
	typedef logic [7:0]  ghr_byte_t;
	typedef logic [11:0] ghr_coord_t;
	typedef enum logic [1:0] {BUS_IDLE, BUS_WAIT, BUS_ACK} ghr_bus_e;
endpackage : ghr_pkg

// file: hdl/ghr_timing_regs.sv
// Indirect timing register file, cell position counters and pen capture.
`timescale 1ns/1ps
`include "ghr_params.svh"
module ghr_timing_regs
(
	input  wire logic              i_clk,
	input  wire logic              i_rst,
	input  wire logic              i_index_we,
	input  wire logic              i_port_we,
	input  wire ghr_pkg::ghr_byte_t i_wdata,
	input  wire logic              i_dot_tick,
	input  wire logic              i_line_tick,
	input  wire logic              i_vblank,
	input  wire logic              i_pen_hit,
	input  wire logic              i_pen_read,
	output ghr_pkg::ghr_byte_t     o_port_rdata,
	output ghr_pkg::ghr_byte_t     o_status,
	output ghr_pkg::ghr_byte_t     o_pen_pos,
	output logic                   o_cell_clk
);
	import ghr_pkg::*;

	ghr_byte_t  regs_q [`GHR_TIMING_REGS];
	logic [3:0] index_q;
	logic [2:0] dot_q;
	logic [2:0] line_q;
	logic       pen_full_q;
	ghr_byte_t  pen_q;
	wire        index_ok = (index_q < 4'(`GHR_TIMING_REGS));

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			index_q <= 4'h0;
		else if (i_index_we)
			index_q <= i_wdata[3:0]; // see R14

	// Indices past the last register are ignored on write and read as zero.
	genvar gi;
	generate
		for (gi = 0; gi < `GHR_TIMING_REGS; gi++)
		begin : g_reg
			always_ff @(posedge i_clk or posedge i_rst)
				if (i_rst)
					regs_q[gi] <= 8'h00;
				else if (i_port_we && index_q == 4'(gi))
					regs_q[gi] <= i_wdata; // see R14
		end
	endgenerate

	assign o_port_rdata = index_ok ? regs_q[index_q] : 8'h00;

	////////////////////////////////////////////////////////////////////////////
	// Cell counters: the timing registers count cells, this counts pixels inside one.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			dot_q  <= 3'h0;
			line_q <= 3'h0;
		end
		else
		begin
			if (i_line_tick)
				dot_q <= 3'h0;
			else if (i_dot_tick)
				dot_q <= dot_q + 3'h1; // see R18
			if (i_vblank)
				line_q <= 3'h0;
			else if (i_line_tick)
				line_q <= line_q + 3'h1; // see R18
		end

	assign o_cell_clk = i_dot_tick && dot_q == 3'(`GHR_CELL_SIZE - 1); // see R18

	// A new hit in the cycle of the clearing read keeps the flag set.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			pen_full_q <= 1'b0;
			pen_q      <= 8'h00;
		end
		else
		begin
			if (i_pen_hit)
				pen_q <= {2'b00, line_q, dot_q}; // see R10
			pen_full_q <= i_pen_hit | (pen_full_q & ~i_pen_read); // see R13
		end

	assign o_pen_pos = pen_q;
	assign o_status  = {1'b0, pen_full_q, i_vblank, 5'h00}; // see R13

	////////////////////////////////////////////////////////////////////////////
	property p_index_port;
		@(posedge i_clk) disable iff (i_rst)
		(i_port_we && index_ok) |=> (o_port_rdata == $past(i_wdata));
	endproperty
	a_index_port: assert property (p_index_port) else $error("timing port write lost"); // see R14

	property p_pen_flag;
		@(posedge i_clk) disable iff (i_rst)
		i_pen_hit |=> o_status[`GHR_TSTAT_PEN_BIT] && o_pen_pos[5:0] == {$past(line_q), $past(dot_q)};
	endproperty
	a_pen_flag: assert property (p_pen_flag) else $error("pen capture wrong"); // see R13
endmodule : ghr_timing_regs

// file: hdl/ghr_host_regs.sv
// Host register decode of the bit-plane graphics controller board.
`timescale 1ns/1ps
`include "ghr_params.svh"
module ghr_host_regs
#(
	parameter int unsigned FRAME_CYCLES = `GHR_FRAME_CYC
)
(
	input  wire logic               i_clk,
	input  wire logic               i_rst,
	input  wire logic [7:0]         i_addr,
	input  wire logic [3:0]         i_base_strap,
	input  wire logic               i_rd_cmd_n,
	input  wire logic               i_wr_cmd_n,
	input  wire logic [7:0]         i_data,
	output ghr_pkg::ghr_byte_t      o_data,
	output logic                    o_data_oe_n,
	output logic                    o_transfer_ack_n,
	output logic                    o_transfer_ack_oe_n,
	input  wire logic [15:0]        i_lane_strap,
	input  wire logic               i_dma_xfer,
	input  wire logic               i_dot_tick,
	input  wire logic               i_line_tick,
	input  wire logic               i_vblank,
	input  wire logic               i_pen_hit,
	output ghr_pkg::ghr_coord_t     o_mem_x,
	output ghr_pkg::ghr_coord_t     o_mem_y,
	output logic                    o_mem_req,
	output logic                    o_mem_we,
	output logic [15:0]             o_mem_wdata,
	input  wire logic               i_mem_ready,
	input  wire logic [15:0]        i_mem_rdata,
	output logic                    o_mem_clip,
	output logic [15:0]             o_plane_write_mask,
	output logic [15:0]             o_output_mask,
	output logic                    o_ttl_output_float,
	output logic                    o_double_horizontal_res,
	output logic                    o_dma_mode,
	output logic                    o_frame_grab_freeze,
	output logic                    o_preset_busy_flag,
	output logic                    o_preset_active,
	output ghr_pkg::ghr_byte_t      o_pan_zoom,
	output logic                    o_cell_clk
);
	import ghr_pkg::*;

	localparam int unsigned SLOW_CYC = `GHR_ACK_SLOW_CYC;
	localparam int unsigned FAST_CYC = `GHR_ACK_FAST_CYC;

	////////////////////////////////////////////////////////////////////////////
	// Bus, strap and video pins pass two flops; i_dot_tick, i_dma_xfer and the memory inputs do not.
	logic [7:0]  addr_s1_q, addr_s2_q, data_s1_q, data_s2_q;
	logic [3:0]  base_s1_q, base_s2_q;
	logic [15:0] lane_s1_q, lane_s2_q;
	logic [4:0]  pin_s1_q, pin_s2_q;
	logic [1:0]  tick_q;

	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			addr_s1_q <= 8'h00;
			addr_s2_q <= 8'h00;
			data_s1_q <= 8'h00;
			data_s2_q <= 8'h00;
			base_s1_q <= 4'h0;
			base_s2_q <= 4'h0;
			lane_s1_q <= 16'h0000;
			lane_s2_q <= 16'h0000;
			pin_s1_q  <= 5'h03;
			pin_s2_q  <= 5'h03;
			tick_q    <= 2'h0;
		end
		else
		begin
			addr_s1_q <= i_addr;
			addr_s2_q <= addr_s1_q;
			data_s1_q <= i_data;
			data_s2_q <= data_s1_q;
			base_s1_q <= i_base_strap;
			base_s2_q <= base_s1_q;
			lane_s1_q <= i_lane_strap;
			lane_s2_q <= lane_s1_q;
			pin_s1_q  <= {i_pen_hit, i_vblank, i_line_tick, i_wr_cmd_n, i_rd_cmd_n};
			pin_s2_q  <= pin_s1_q;
			tick_q    <= {pin_s2_q[4], pin_s2_q[2]};
		end

	wire       rd_act   = ~pin_s2_q[0];
	wire       wr_act   = ~pin_s2_q[1];
	wire       line_p   = pin_s2_q[2] & ~tick_q[0];
	wire       vblank_s = pin_s2_q[3];
	wire       pen_p    = pin_s2_q[4] & ~tick_q[1];
	wire       hit      = addr_s2_q[7:4] == base_s2_q; // see R24
	wire [3:0] ofs      = addr_s2_q[3:0]; // see R24

	////////////////////////////////////////////////////////////////////////////
	ghr_bus_e    st_q;
	logic [2:0]  cnt_q;
	ghr_byte_t   rdata_q;
	ghr_coord_t  x_q, y_q;
	logic [15:0] pix_q, omask_q, wmask_q;
	ghr_byte_t   ctrl1_q, pz_q;
	logic        req_q, we_q, mem_rd_q;
	logic [31:0] preset_cnt_q;

	wire go     = st_q == BUS_IDLE && hit && (rd_act ^ wr_act);
	wire wr_go  = go && wr_act; // see R24
	wire rd_go  = go && rd_act; // see R24
	wire slow   = ofs <= `GHR_OFS_STATUS_CTRL1 || ofs == `GHR_OFS_LINE_STEP;
	wire w00    = wr_go && ofs == `GHR_OFS_X_LOW;
	wire w01    = wr_go && ofs == `GHR_OFS_X_HIGH;
	wire w02    = wr_go && ofs == `GHR_OFS_Y_LOW;
	wire w03    = wr_go && ofs == `GHR_OFS_Y_HIGH;
	wire w04    = wr_go && ofs == `GHR_OFS_DATA_LOW;
	wire w05    = wr_go && ofs == `GHR_OFS_DATA_HIGH;
	wire w06    = wr_go && ofs == `GHR_OFS_STATUS_CTRL1;
	wire w07    = wr_go && ofs == `GHR_OFS_PAN_ZOOM;
	wire w08    = wr_go && ofs == `GHR_OFS_PEN_OMASK_LO;
	wire w09    = wr_go && ofs == `GHR_OFS_OMASK_HI;
	wire w0a    = wr_go && ofs == `GHR_OFS_WMASK_LO;
	wire w0b    = wr_go && ofs == `GHR_OFS_WMASK_HI;
	wire w0c    = wr_go && ofs == `GHR_OFS_TSTAT_INDEX;
	wire w0e    = wr_go && ofs == `GHR_OFS_TPORT;
	wire w0f    = wr_go && ofs == `GHR_OFS_LINE_STEP;
	wire r_pix  = rd_go && (ofs == `GHR_OFS_DATA_LOW || ofs == `GHR_OFS_DATA_HIGH);
	wire r08    = rd_go && ofs == `GHR_OFS_PEN_OMASK_LO;
	wire dma    = ctrl1_q[`GHR_CTRL1_DMA_BIT];
	wire step_w = w0f && data_s2_q[`GHR_STEP_WRITE];
	wire mem_go = w04 || w05 || step_w || r_pix; // see R5
	wire preset = preset_cnt_q != 32'h0;
	wire busy   = preset || !ctrl1_q[`GHR_CTRL1_FREEZE_BIT]; // see R21
	wire ack    = st_q == BUS_ACK;

	ghr_byte_t tport, tstat, pen_pos, status, rd_mux;
	logic [15:0] lanes_in;

	assign status = {busy, 6'h00, ~preset}; // see R6
	assign lanes_in = {data_s2_q, data_s2_q} & lane_s2_q; // see R5

	// Unselected lanes read as zero.
	always_comb
	begin
		unique case (ofs)
			`GHR_OFS_DATA_LOW:     rd_mux = pix_q[7:0] & lane_s2_q[7:0]; // see R5
			`GHR_OFS_DATA_HIGH:    rd_mux = pix_q[15:8] & lane_s2_q[15:8];
			`GHR_OFS_STATUS_CTRL1: rd_mux = status; // see R6
			`GHR_OFS_PEN_OMASK_LO: rd_mux = pen_pos; // see R10
			`GHR_OFS_TSTAT_INDEX:  rd_mux = tstat; // see R13
			`GHR_OFS_TPORT:        rd_mux = tport; // see R14
			default:               rd_mux = 8'h00;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// The acknowledge waits for the fixed access time and for any memory cycle.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			st_q    <= BUS_IDLE;
			cnt_q   <= 3'h0;
			rdata_q <= 8'h00;
		end
		else
		begin
			unique case (st_q)
				BUS_IDLE:
					if (go)
					begin
						st_q  <= BUS_WAIT;
						cnt_q <= slow ? 3'(SLOW_CYC - 1) : 3'(FAST_CYC - 1);
					end
				BUS_WAIT:
					if (cnt_q != 3'h0)
						cnt_q <= cnt_q - 3'h1;
					else if (!req_q)
					begin
						st_q    <= BUS_ACK;
						rdata_q <= rd_mux;
					end
				BUS_ACK:
					if (!rd_act && !wr_act)
						st_q <= BUS_IDLE;
			endcase
		end

	assign o_transfer_ack_n    = ~ack;
	assign o_transfer_ack_oe_n = ~ack;
	assign o_data              = rdata_q;
	assign o_data_oe_n         = ~(ack && rd_act);

	////////////////////////////////////////////////////////////////////////////
	// Coordinates: direct loads, line stepping and DMA pre-increment share one register.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			x_q <= 12'h000;
			y_q <= 12'h000;
		end
		else if (dma && i_dma_xfer)
		begin
			x_q <= x_q + 12'h001; // see R22
			if (x_q == 12'hfff)
				y_q <= y_q + 12'h001;
		end
		else
		begin
			if (w00)
				x_q[7:0] <= data_s2_q; // see R1
			if (w01)
				x_q[11:8] <= data_s2_q[3:0]; // see R2
			if (w02)
				y_q[7:0] <= data_s2_q; // see R3
			if (w03)
				y_q[11:8] <= data_s2_q[3:0]; // see R4
			if (w0f && data_s2_q[`GHR_STEP_X_INC])
				x_q <= x_q + 12'h001; // see R15
			else if (w0f && data_s2_q[`GHR_STEP_X_DEC])
				x_q <= x_q - 12'h001; // see R15
			if (w0f && data_s2_q[`GHR_STEP_Y_INC])
				y_q <= y_q + 12'h001; // see R15
			else if (w0f && data_s2_q[`GHR_STEP_Y_DEC])
				y_q <= y_q - 12'h001; // see R15
		end

	assign o_mem_x    = x_q;
	assign o_mem_y    = y_q;
	assign o_mem_clip = !dma && (x_q[11:9] != 3'h0 || y_q[11:9] != 3'h0); // see R20

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			pix_q   <= 16'h0000;
			ctrl1_q <= `GHR_RST_CTRL1;
			pz_q    <= `GHR_RST_PAN_ZOOM;
			omask_q <= `GHR_RST_MASK;
			wmask_q <= `GHR_RST_MASK;
		end
		else
		begin
			if (w04)
				pix_q[7:0] <= lanes_in[7:0]; // see R5
			if (w05)
				pix_q[15:8] <= lanes_in[15:8]; // see R5
			if (req_q && mem_rd_q && i_mem_ready)
				pix_q <= i_mem_rdata & lane_s2_q; // see R5
			if (w06)
				ctrl1_q <= data_s2_q; // see R7
			if (w07)
				pz_q <= data_s2_q; // see R9
			if (w08)
				omask_q[7:0] <= data_s2_q; // see R11
			if (w09)
				omask_q[15:8] <= data_s2_q; // see R11
			if (w0a)
				wmask_q[7:0] <= data_s2_q; // see R12
			if (w0b)
				wmask_q[15:8] <= data_s2_q; // see R12
		end

	// A preset runs for one frame; a second start restarts the count.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
			preset_cnt_q <= 32'h0;
		else if (w06 && data_s2_q[`GHR_CTRL1_PRESET_BIT])
			preset_cnt_q <= 32'(FRAME_CYCLES); // see R17
		else if (preset)
			preset_cnt_q <= preset_cnt_q - 32'h1;

	// Memory request stays up until the memory side accepts it.
	always_ff @(posedge i_clk or posedge i_rst)
		if (i_rst)
		begin
			req_q    <= 1'b0;
			we_q     <= 1'b0;
			mem_rd_q <= 1'b0;
		end
		else if (mem_go && !o_mem_clip)
		begin
			req_q    <= 1'b1;
			we_q     <= !r_pix;
			mem_rd_q <= r_pix;
		end
		else if (i_mem_ready)
		begin
			req_q    <= 1'b0;
			mem_rd_q <= 1'b0;
		end

	assign o_mem_req               = req_q;
	assign o_mem_we                = we_q;
	assign o_mem_wdata             = pix_q;
	assign o_plane_write_mask      = wmask_q; // see R12
	assign o_output_mask           = omask_q; // see R11
	assign o_ttl_output_float      = ctrl1_q[`GHR_CTRL1_FLOAT_BIT]; // see R23
	assign o_double_horizontal_res = ctrl1_q[`GHR_CTRL1_DBLRES_BIT]; // see R23
	assign o_dma_mode              = dma;
	assign o_frame_grab_freeze     = ctrl1_q[`GHR_CTRL1_FREEZE_BIT];
	assign o_preset_busy_flag      = busy;
	assign o_preset_active         = preset; // see R17
	assign o_pan_zoom              = pz_q;

	////////////////////////////////////////////////////////////////////////////
	ghr_timing_regs u_timing
	(
		.i_clk        (i_clk),
		.i_rst        (i_rst),
		.i_index_we   (w0c),
		.i_port_we    (w0e),
		.i_wdata      (data_s2_q),
		.i_dot_tick   (i_dot_tick),
		.i_line_tick  (line_p),
		.i_vblank     (vblank_s),
		.i_pen_hit    (pen_p),
		.i_pen_read   (r08),
		.o_port_rdata (tport),
		.o_status     (tstat),
		.o_pen_pos    (pen_pos),
		.o_cell_clk   (o_cell_clk)
	);

	////////////////////////////////////////////////////////////////////////////
	property p_ack_slow;
		@(posedge i_clk) disable iff (i_rst)
		(go && slow) |=> !ack [*5];
	endproperty
	a_ack_slow: assert property (p_ack_slow) else $error("slow access acked early"); // see R24

	property p_ack_fast;
		@(posedge i_clk) disable iff (i_rst)
		(go && !slow && !mem_go && !req_q) |-> ##2 ack;
	endproperty
	a_ack_fast: assert property (p_ack_fast) else $error("fast access ack late"); // see R24

	property p_x_low;
		@(posedge i_clk) disable iff (i_rst)
		(w00 && !(dma && i_dma_xfer)) |=> x_q[7:0] == $past(data_s2_q);
	endproperty
	a_x_low: assert property (p_x_low) else $error("x low not loaded"); // see R1

	property p_y_high;
		@(posedge i_clk) disable iff (i_rst)
		(w03 && !(dma && i_dma_xfer)) |=> y_q[11:8] == $past(data_s2_q[3:0]);
	endproperty
	a_y_high: assert property (p_y_high) else $error("y high not loaded"); // see R4

	property p_clip;
		@(posedge i_clk) disable iff (i_rst)
		(mem_go && o_mem_clip && !req_q) |=> !req_q;
	endproperty
	a_clip: assert property (p_clip) else $error("clipped access reached memory"); // see R20

	property p_step;
		@(posedge i_clk) disable iff (i_rst)
		(w0f && data_s2_q[3:0] == 4'h1 && !(dma && i_dma_xfer))
			|=> x_q == $past(x_q) + 12'h001 && y_q == $past(y_q);
	endproperty
	a_step: assert property (p_step) else $error("line step wrong"); // see R15

	property p_preset;
		@(posedge i_clk) disable iff (i_rst)
		(w06 && data_s2_q[`GHR_CTRL1_PRESET_BIT]) |=> o_preset_active && o_preset_busy_flag;
	endproperty
	a_preset: assert property (p_preset) else $error("preset did not start"); // see R21

	property p_ctrl_out;
		@(posedge i_clk) disable iff (i_rst)
		w06 |=> o_ttl_output_float == $past(data_s2_q[2]) && o_double_horizontal_res == $past(data_s2_q[3]);
	endproperty
	a_ctrl_out: assert property (p_ctrl_out) else $error("control outputs wrong"); // see R23

	property p_dma_inc;
		@(posedge i_clk) disable iff (i_rst)
		(dma && i_dma_xfer && x_q != 12'hfff) |=> x_q == $past(x_q) + 12'h001;
	endproperty
	a_dma_inc: assert property (p_dma_inc) else $error("dma increment missing"); // see R22

	property p_wmask;
		@(posedge i_clk) disable iff (i_rst)
		w0a |=> o_plane_write_mask[7:0] == $past(data_s2_q);
	endproperty
	a_wmask: assert property (p_wmask) else $error("write mask not loaded"); // see R12
endmodule : ghr_host_regs

// file: bench/ghr_host_model.sv
// Host bus master model that drives the board's I/O command pins.
`timescale 1ns/1ps
module ghr_host_model
(
	input  wire logic       i_clk,
	input  wire logic       i_ack_n,
	input  wire logic [7:0] i_rdata,
	output logic [7:0]      o_addr,
	output logic            o_rd_cmd_n,
	output logic            o_wr_cmd_n,
	output logic [7:0]      o_data,
	output logic            o_hang
);
	initial
	begin
		o_addr = 8'h00;
		o_rd_cmd_n = 1'b1;
		o_wr_cmd_n = 1'b1;
		o_data = 8'h00;
		o_hang = 1'b0;
	end

	////////////////////////////////////////////////////////////////
	// One command held until acknowledge is sampled low at a rising edge.
	task automatic cycle(input logic [7:0] a, input logic wr, input logic [7:0] d,
		output logic [7:0] q);
		int n;
		@(negedge i_clk);
		o_addr = a;
		o_data = d;
		o_wr_cmd_n = !wr;
		o_rd_cmd_n = wr;
		for (n = 0; n < 40 && i_ack_n !== 1'b0; n++)
			@(posedge i_clk);
		q = i_rdata;
		o_hang = (n == 40);
		@(negedge i_clk);
		o_wr_cmd_n = 1'b1;
		o_rd_cmd_n = 1'b1;
		// Released lines show the inverse so a stale value is never mistaken for live data.
		o_addr = ~a;
		o_data = ~d;
		for (n = 0; n < 40 && i_ack_n !== 1'b1; n++)
			@(posedge i_clk);
		o_hang = o_hang | (n == 40);
	endtask : cycle
endmodule : ghr_host_model

// file: bench/test_graphics_host_register_decode.sv
// Self-checking bench for the host register decode.
`timescale 1ns/1ps
`include "ghr_params.svh"
module test_graphics_host_register_decode;
	import ghr_pkg::*;
	localparam int unsigned FRAME = 60;
	logic        i_clk, i_rst, rd_cmd_n, wr_cmd_n, ack_n, hang, dot_tick, vblank;
	logic        mem_req, mem_ready, clip, ttl_float, dbl_res, dma, busy, preset_act;
	logic        mem_we, we_last, freeze, dma_xfer = 1'b0, pen_hit = 1'b0, line_tick = 1'b0;
	logic [7:0]  addr, wdata;
	ghr_byte_t   rdata, pan_zoom, got;
	ghr_coord_t  mem_x, mem_y, x, y;
	logic [15:0] mem_rdata, wmask, omask, m, mem_wdata, mem_last, wd_last;
	logic [7:0]  tv [15];
	int          seed = 32'h91a47856;
	int          fail_count = 0;
	int          n_checks = 0;
	int          i;

	ghr_host_regs #(.FRAME_CYCLES(FRAME)) ghr_host_regs_i (
		.i_clk(i_clk), .i_rst(i_rst), .i_addr(addr), .i_base_strap(4'ha),
		.i_rd_cmd_n(rd_cmd_n), .i_wr_cmd_n(wr_cmd_n), .i_data(wdata),
		.o_data(rdata), .o_data_oe_n(), .o_transfer_ack_n(ack_n),
		.o_transfer_ack_oe_n(), .i_lane_strap(16'h000f), .i_dma_xfer(dma_xfer),
		.i_dot_tick(dot_tick), .i_line_tick(line_tick), .i_vblank(vblank),
		.i_pen_hit(pen_hit), .o_mem_x(mem_x), .o_mem_y(mem_y), .o_mem_req(mem_req),
		.o_mem_we(mem_we), .o_mem_wdata(mem_wdata), .i_mem_ready(mem_ready),
		.i_mem_rdata(mem_rdata), .o_mem_clip(clip), .o_plane_write_mask(wmask),
		.o_output_mask(omask), .o_ttl_output_float(ttl_float),
		.o_double_horizontal_res(dbl_res), .o_dma_mode(dma),
		.o_frame_grab_freeze(freeze), .o_preset_busy_flag(busy),
		.o_preset_active(preset_act), .o_pan_zoom(pan_zoom), .o_cell_clk());

	ghr_host_model ghr_host_model_i (
		.i_clk(i_clk), .i_ack_n(ack_n), .i_rdata(rdata), .o_addr(addr),
		.o_rd_cmd_n(rd_cmd_n), .o_wr_cmd_n(wr_cmd_n), .o_data(wdata), .o_hang(hang));

	initial
	begin
		i_clk = 1'b0;
		forever #50 i_clk = ~i_clk;
	end

	// The memory answers one cycle after each request so accesses never stall forever.
	always @(negedge i_clk)
	begin
		mem_ready <= mem_req & ~mem_ready;
		mem_rdata <= 16'($random(seed));
		dot_tick <= 1'($random(seed));
		vblank <= 1'($random(seed));
		line_tick <= 1'($random(seed));
	end

	// What the memory side saw at each accepted request.
	always @(posedge i_clk)
		if (mem_req && mem_ready)
		begin
			mem_last <= mem_rdata;
			wd_last <= mem_wdata;
			we_last <= mem_we;
		end

	////////////////////////////////////////////////////////////////
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test();
		$display("checks %0d mismatches %0d", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test

	task automatic bus(input logic [3:0] ofs, input logic wr, input logic [7:0] d);
		ghr_host_model_i.cycle({4'ha, ofs}, wr, d, got);
		if (hang)
		begin
			fail_count++;
			stop_test();
		end
	endtask : bus

	function automatic ghr_coord_t stepped(ghr_coord_t c, logic up, logic dn);
		return up ? c + 12'h001 : (dn ? c - 12'h001 : c);
	endfunction : stepped

	////////////////////////////////////////////////////////////////
	initial
	begin
		i_rst = 1'b1;
		dot_tick = 1'b0;
		vblank = 1'b0;
		mem_ready = 1'b0;
		mem_rdata = 16'h0000;
		repeat (3) @(negedge i_clk);
		i_rst = 1'b0;
		check(wmask, `GHR_RST_MASK);
		check(omask, `GHR_RST_MASK);
		check(pan_zoom, `GHR_RST_PAN_ZOOM);
		$display("reset test done");
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h20);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h20);
		check(ttl_float, 1'b0);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h2c);
		check({freeze, dma, dbl_res, ttl_float}, 4'b1011);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h20);
		$display("control test done");
		repeat (4)
		begin
			x = 12'($random(seed)) & 12'h1ff;
			y = 12'($random(seed)) & 12'h1ff;
			bus(`GHR_OFS_X_LOW, 1'b1, x[7:0]);
			bus(`GHR_OFS_X_HIGH, 1'b1, {4'h0, x[11:8]});
			bus(`GHR_OFS_Y_LOW, 1'b1, y[7:0]);
			bus(`GHR_OFS_Y_HIGH, 1'b1, {4'h0, y[11:8]});
			check(mem_x, x);
			check(mem_y, y);
			check(clip, 1'b0);
			bus(`GHR_OFS_LINE_STEP, 1'b1, 8'h07);
			check(mem_x, stepped(x, 1'b1, 1'b1));
			check(mem_y, stepped(y, 1'b1, 1'b0));
			bus(`GHR_OFS_LINE_STEP, 1'b1, 8'h0a);
			check(mem_x, x);
			check(mem_y, y);
			bus(`GHR_OFS_LINE_STEP, 1'b1, 8'h01);
			check(mem_x, stepped(x, 1'b1, 1'b0));
			bus(`GHR_OFS_Y_HIGH, 1'b1, 8'h04);
			check(clip, 1'b1);
		end
		$display("coordinate test done");
		m = 16'($random(seed));
		bus(`GHR_OFS_PEN_OMASK_LO, 1'b1, m[7:0]);
		bus(`GHR_OFS_OMASK_HI, 1'b1, m[15:8]);
		bus(`GHR_OFS_WMASK_LO, 1'b1, ~m[7:0]);
		bus(`GHR_OFS_WMASK_HI, 1'b1, ~m[15:8]);
		check(omask, m);
		check(wmask, ~m);
		bus(`GHR_OFS_PAN_ZOOM, 1'b1, m[7:0]);
		check(pan_zoom, m[7:0]);
		bus(`GHR_OFS_WMASK_LO, 1'b1, 8'hff);
		bus(`GHR_OFS_WMASK_HI, 1'b1, 8'hff);
		check(wmask, 16'hffff);
		$display("mask test done");
		bus(`GHR_OFS_X_LOW, 1'b1, 8'h10);
		bus(`GHR_OFS_X_HIGH, 1'b1, 8'h00);
		bus(`GHR_OFS_Y_HIGH, 1'b1, 8'h00);
		m = 16'($random(seed));
		bus(`GHR_OFS_DATA_LOW, 1'b1, m[7:0]);
		check(we_last, 1'b1);
		check(wd_last, {12'h000, m[3:0]});
		bus(`GHR_OFS_DATA_HIGH, 1'b1, 8'hff);
		check(wd_last, {12'h000, m[3:0]});
		bus(`GHR_OFS_DATA_LOW, 1'b0, 8'h00);
		check(got, mem_last[7:0] & 8'h0f);
		check(we_last, 1'b0);
		bus(`GHR_OFS_DATA_HIGH, 1'b0, 8'h00);
		check(got, 8'h00);
		m = mem_last & 16'h000f;
		bus(`GHR_OFS_LINE_STEP, 1'b1, 8'h11);
		check(wd_last, m);
		check(we_last, 1'b1);
		check(mem_x, stepped(12'h010, 1'b1, 1'b0));
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h30);
		check(dma, 1'b1);
		bus(`GHR_OFS_Y_HIGH, 1'b1, 8'h02);
		check(clip, 1'b0);
		@(negedge i_clk) dma_xfer = 1'b1;
		@(negedge i_clk) dma_xfer = 1'b0;
		check(mem_x, 12'h012);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'h20);
		check(clip, 1'b1);
		$display("pixel test done");
		for (i = 0; i < 15; i++)
		begin
			tv[i] = 8'($random(seed));
			bus(`GHR_OFS_TSTAT_INDEX, 1'b1, 8'(i));
			bus(`GHR_OFS_TPORT, 1'b1, tv[i]);
		end
		for (i = 0; i < 15; i++)
		begin
			bus(`GHR_OFS_TSTAT_INDEX, 1'b1, 8'(i));
			bus(`GHR_OFS_TPORT, 1'b0, 8'h00);
			check(got, (i < `GHR_TIMING_REGS) ? tv[i] : 8'h00);
		end
		bus(4'hd, 1'b0, 8'h00);
		check(got, 8'h00);
		bus(`GHR_OFS_PEN_OMASK_LO, 1'b0, 8'h00);
		bus(`GHR_OFS_TSTAT_INDEX, 1'b0, 8'h00);
		check(got & 8'hdf, 8'h00);
		@(negedge i_clk) pen_hit = 1'b1;
		repeat (4) @(negedge i_clk);
		pen_hit = 1'b0;
		bus(`GHR_OFS_TSTAT_INDEX, 1'b0, 8'h00);
		check(got & 8'hdf, 8'h40);
		bus(`GHR_OFS_PEN_OMASK_LO, 1'b0, 8'h00);
		check(got[7:6], 2'b00);
		bus(`GHR_OFS_TSTAT_INDEX, 1'b0, 8'h00);
		check(got & 8'hdf, 8'h00);
		$display("timing register test done");
		bus(`GHR_OFS_DATA_LOW, 1'b1, 8'h00);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b1, 8'ha0);
		check(busy, 1'b1);
		bus(`GHR_OFS_STATUS_CTRL1, 1'b0, 8'h00);
		check(got[`GHR_STAT_BUSY_BIT], 1'b1);
		for (i = 0; i < 200 && busy !== 1'b0; i++)
			@(negedge i_clk);
		check(busy, 1'b0);
		check(preset_act, 1'b0);
		$display("preset test done");
		stop_test();
	end
endmodule : test_graphics_host_register_decode
